// *** cfg_regs_pkg.sv ***
// package for the capability-2 and error reporting register bank
// assumes a 12-bit configuration byte address, 32-bit data words
package cfg_regs_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] DEV_CAP2_OFF   = 12'h0A4;
    localparam logic [11:0] DEV_CTL2_OFF   = 12'h0A8;
    localparam logic [11:0] LNK_CAP2_OFF   = 12'h0AC;
    localparam logic [11:0] LNK_CTL2_OFF   = 12'h0B0;
    localparam logic [11:0] ERR_HDR_OFF    = 12'h100;
    localparam logic [11:0] UNCORR_OFF     = 12'h104;
    localparam logic [11:0] INT_STAT_OFF   = 12'h180;
    localparam logic [11:0] INT_MASK_OFF   = 12'h184;

    // ------------------------------------------------------------
    // reset values, field positions, fixed codes
    // ------------------------------------------------------------
    localparam logic [3:0]  CTO_VALUE_RST  = 4'hF;
    localparam logic        CTO_DIS_RST    = 1'b1;
    localparam logic        ATOMIC_RST     = 1'b0;
    localparam logic        HASD_RST       = 1'b0;
    localparam logic [3:0]  TGT_SPEED_RST  = 4'h1;
    localparam logic [3:0]  SPEED_GEN3     = 4'h3;
    localparam int          EQ_REQ_POS     = 21;
    localparam logic [15:0] ECAP_ID        = 16'h0001;
    localparam logic [3:0]  ECAP_VER       = 4'h2;
    localparam logic [11:0] PTR_ARI        = 12'h160;
    localparam logic [11:0] PTR_SEC        = 12'h280;
    localparam logic [11:0] PTR_TPH        = 12'h300;
    localparam logic [11:0] PTR_ATS        = 12'h3C0;
    localparam logic [11:0] PTR_NONE       = 12'h000;
    localparam logic [31:0] UNCORR_IMPL    = 32'h001FF010;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [11:0] araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_t;

    // one-cycle error events, ordered as status bits 20 down to 12, 4
    typedef struct packed {
        logic ur;
        logic ecrc;
        logic malformed;
        logic overflow;
        logic unexp_cpl;
        logic ca_sent;
        logic cpl_timeout;
        logic fc_proto;
        logic poisoned;
        logic dl_proto;
    } err_evt_t;

    typedef struct packed {
        logic req_set;
        logic ph3_ok;
        logic ph2_ok;
        logic ph1_ok;
        logic complete;
    } eq_stat_t;

    typedef struct packed {
        logic       atomic_req_en;
        logic       cto_disable;
        logic [3:0] cto_value;
    } dev_ctl_t;

    typedef struct packed {
        logic [3:0] compl_preset;
        logic       compl_sos;
        logic       mod_compl;
        logic [2:0] tx_margin;
        logic       enter_compl;
        logic [3:0] target_speed;
    } link_ctl_t;

endpackage

// *** cfg_cap2_err_regs.sv ***
// configuration register bank: capability 2 registers, error header,
// uncorrectable error status, plus interrupt status and mask
// assumes AXI4-Lite master on clk_in, error and equalization events
// from logic on the same clock, power-on reset asserted with resetn_in
//
// Functional notes
// - device caps 2: timeout ranges [3:0], disable-supported [4], fixed
// - device control 2: timeout value 0xF, disable 1, atomic enable 0
// - link control 2 sticky fields; hardware speed disable bit 5 plain
// - link status 2 bits 17-20 read-only; bit 21 cleared by writing one
// - error header: id 0x0001 in [15:0], version 2 in [19:16]
// - next pointer 0x160 with ARI, else fn0 at 8 GT/s gives 0x280
// - fn0 at lower speeds: TPH 0x300 if present, else ATS 0x3C0
// - functions 1-3: TPH, else ATS; all other cases read zero
// - status bits 20,19,18,17 set by UR, ECRC, malformed, overflow
// - status bits 16,15,14: unexpected cpl, abort sent, timeout
// - bits 13,12,4: flow control, poisoned, link protocol; reserved zero
// - every recorded error is forwarded as internal uncorrectable error
`timescale 1ns/10ps

module cfg_cap2_err_regs #(
    parameter logic [3:0] CPL_TO_RANGES  = 4'h0,
    parameter logic       CPL_TO_DIS_SUP = 1'b1,
    parameter logic [2:0] LINK_SPEEDS    = 3'h1,
    parameter logic [3:0] MAX_LINK_SPEED = 4'h1,
    parameter logic       ARI_SUPPORTED  = 1'b0,
    parameter logic [2:0] FUNC_NUM       = 3'h0,
    parameter logic       TPH_PRESENT    = 1'b0,
    parameter logic       ATS_PRESENT    = 1'b0
) (
    // clock and resets
    input  wire logic                     clk_in,
    input  wire logic                     resetn_in,
    input  wire logic                     por_resetn_in,
    // register bus
    input  wire cfg_regs_pkg::axi_req_t   axi_req_in,
    output      cfg_regs_pkg::axi_rsp_t   axi_rsp_out,
    // events and status from the link and transaction layers
    input  wire cfg_regs_pkg::err_evt_t   err_evt_in,
    input  wire cfg_regs_pkg::eq_stat_t   eq_stat_in,
    // control towards the core
    output      cfg_regs_pkg::dev_ctl_t   dev_ctl_out,
    output      cfg_regs_pkg::link_ctl_t  link_ctl_out,
    output      logic                     hw_speed_dis_out,
    output      logic                     uncorr_err_out,
    output      logic                     irq_out
);
    import cfg_regs_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------

    // expand byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // true for every word the bank answers
    function automatic logic is_mapped(input logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        return (w == DEV_CAP2_OFF) || (w == DEV_CTL2_OFF) ||
               (w == LNK_CAP2_OFF) || (w == LNK_CTL2_OFF) ||
               (w == ERR_HDR_OFF)  || (w == UNCORR_OFF)   ||
               (w == INT_STAT_OFF) || (w == INT_MASK_OFF);
    endfunction

    // word address compare, low two bits ignored
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        return {a[11:2], 2'b00} == off;
    endfunction

    // next capability pointer selection
    function automatic logic [11:0] next_ptr();
        logic [11:0] p;
        p = PTR_NONE;
        if (ARI_SUPPORTED) begin
            p = PTR_ARI;
        end else if (FUNC_NUM == 3'h0) begin
            if (MAX_LINK_SPEED == SPEED_GEN3) begin
                p = PTR_SEC;
            end else if (TPH_PRESENT) begin
                p = PTR_TPH;
            end else if (ATS_PRESENT) begin
                p = PTR_ATS;
            end
        end else if (FUNC_NUM <= 3'h3) begin
            if (TPH_PRESENT) begin
                p = PTR_TPH;
            end else if (ATS_PRESENT) begin
                p = PTR_ATS;
            end
        end
        return p;
    endfunction

    localparam logic [11:0] NEXT_PTR = next_ptr();

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        axi_rsp_t    rsp;
        logic        aw_have;
        logic [11:0] aw_addr;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        dev_ctl_t    dev;
        logic        hasd;
        logic [31:0] uncorr;
        logic        eq_req;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic        irq;
        logic        uncorr_err;
    } state_t;

    state_t    st_ff;
    state_t    nxt_st;
    link_ctl_t lnk_ff;
    link_ctl_t nxt_lnk;

    logic        wr_go;
    logic [31:0] bm;
    logic [31:0] wd;
    logic [31:0] clr;
    logic [31:0] ev;
    logic [31:0] rd;
    logic [31:0] lnk_word;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------

    // link control 2 and status 2 as one word
    always_comb begin
        lnk_word = {10'h000,
                    st_ff.eq_req,
                    eq_stat_in.ph3_ok,
                    eq_stat_in.ph2_ok,
                    eq_stat_in.ph1_ok,
                    eq_stat_in.complete,
                    1'b0,
                    lnk_ff.compl_preset,
                    lnk_ff.compl_sos,
                    lnk_ff.mod_compl,
                    lnk_ff.tx_margin,
                    1'b0,
                    st_ff.hasd,
                    lnk_ff.enter_compl,
                    lnk_ff.target_speed};
    end

    // read multiplexer, unmapped words read zero
    always_comb begin
        rd = 32'h00000000;
        if (hit(axi_req_in.araddr, DEV_CAP2_OFF)) begin
            rd = {27'h0000000, CPL_TO_DIS_SUP, CPL_TO_RANGES};
        end else if (hit(axi_req_in.araddr, DEV_CTL2_OFF)) begin
            rd = {25'h0000000, st_ff.dev.atomic_req_en, 1'b0,
                  st_ff.dev.cto_disable, st_ff.dev.cto_value};
        end else if (hit(axi_req_in.araddr, LNK_CAP2_OFF)) begin
            rd = {28'h0000000, LINK_SPEEDS, 1'b0};
        end else if (hit(axi_req_in.araddr, LNK_CTL2_OFF)) begin
            rd = lnk_word;
        end else if (hit(axi_req_in.araddr, ERR_HDR_OFF)) begin
            rd = {NEXT_PTR, ECAP_VER, ECAP_ID};
        end else if (hit(axi_req_in.araddr, UNCORR_OFF)) begin
            rd = st_ff.uncorr & UNCORR_IMPL;
        end else if (hit(axi_req_in.araddr, INT_STAT_OFF)) begin
            rd = {30'h00000000, st_ff.int_stat};
        end else if (hit(axi_req_in.araddr, INT_MASK_OFF)) begin
            rd = {30'h00000000, st_ff.int_mask};
        end
    end

    // ------------------------------------------------------------
    // error events into status bit positions
    // ------------------------------------------------------------
    always_comb begin
        ev = 32'h00000000;
        ev[20] = err_evt_in.ur;
        ev[19] = err_evt_in.ecrc;
        ev[18] = err_evt_in.malformed;
        ev[17] = err_evt_in.overflow;
        ev[16] = err_evt_in.unexp_cpl;
        ev[15] = err_evt_in.ca_sent;
        ev[14] = err_evt_in.cpl_timeout;
        ev[13] = err_evt_in.fc_proto;
        ev[12] = err_evt_in.poisoned;
        ev[4]  = err_evt_in.dl_proto;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // write strobe and its masked data
    assign wr_go = st_ff.aw_have && st_ff.w_have && !st_ff.rsp.bvalid;
    assign bm    = strb_mask(st_ff.w_strb);
    assign wd    = st_ff.w_data & bm;
    assign clr   = wr_go ? wd : 32'h00000000;

    // bus channels, register writes and event capture
    always_comb begin
        nxt_st  = st_ff;
        nxt_lnk = lnk_ff;

        // write address and data are taken in either order
        if (axi_req_in.awvalid && st_ff.rsp.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && st_ff.rsp.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = axi_req_in.wdata;
            nxt_st.w_strb = axi_req_in.wstrb;
        end

        // write response once both halves are held
        if (wr_go) begin
            nxt_st.aw_have   = 1'b0;
            nxt_st.w_have    = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            nxt_st.rsp.bresp = is_mapped(st_ff.aw_addr) ?
                               RESP_OKAY : RESP_SLVERR;
        end else if (st_ff.rsp.bvalid && axi_req_in.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
        end
        nxt_st.rsp.awready = !nxt_st.aw_have && !nxt_st.rsp.bvalid;
        nxt_st.rsp.wready  = !nxt_st.w_have && !nxt_st.rsp.bvalid;

        // read channel, one read in flight
        if (axi_req_in.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata  = rd;
            nxt_st.rsp.rresp  = is_mapped(axi_req_in.araddr) ?
                                RESP_OKAY : RESP_SLVERR;
        end else if (st_ff.rsp.rvalid && axi_req_in.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
        end
        nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

        // device control 2 fields
        if (wr_go && hit(st_ff.aw_addr, DEV_CTL2_OFF)) begin
            if (bm[0]) begin
                nxt_st.dev.cto_value     = st_ff.w_data[3:0];
                nxt_st.dev.cto_disable   = st_ff.w_data[4];
                nxt_st.dev.atomic_req_en = st_ff.w_data[6];
            end
        end

        // link control 2, sticky fields and the plain bit 5
        if (wr_go && hit(st_ff.aw_addr, LNK_CTL2_OFF)) begin
            if (bm[0]) begin
                nxt_lnk.target_speed  = st_ff.w_data[3:0];
                nxt_lnk.enter_compl   = st_ff.w_data[4];
                nxt_st.hasd           = st_ff.w_data[5];
                nxt_lnk.tx_margin[0]  = st_ff.w_data[7];
            end
            if (bm[8]) begin
                nxt_lnk.tx_margin[2:1] = st_ff.w_data[9:8];
                nxt_lnk.mod_compl     = st_ff.w_data[10];
                nxt_lnk.compl_sos     = st_ff.w_data[11];
                nxt_lnk.compl_preset  = st_ff.w_data[15:12];
            end
        end

        // equalization request: set by the link, cleared by a one
        if (hit(st_ff.aw_addr, LNK_CTL2_OFF) && clr[EQ_REQ_POS]) begin
            nxt_st.eq_req = 1'b0;
        end
        if (eq_stat_in.req_set) begin
            nxt_st.eq_req = 1'b1;
        end

        // uncorrectable status: events win over a clearing write
        if (hit(st_ff.aw_addr, UNCORR_OFF)) begin
            nxt_st.uncorr = st_ff.uncorr & ~clr;
        end
        nxt_st.uncorr = (nxt_st.uncorr | ev) & UNCORR_IMPL;

        // interrupt status and mask
        if (hit(st_ff.aw_addr, INT_STAT_OFF)) begin
            nxt_st.int_stat = st_ff.int_stat & ~clr[1:0];
        end
        if (|ev) begin
            nxt_st.int_stat[0] = 1'b1;
        end
        if (eq_stat_in.req_set) begin
            nxt_st.int_stat[1] = 1'b1;
        end
        if (wr_go && hit(st_ff.aw_addr, INT_MASK_OFF) && bm[0]) begin
            nxt_st.int_mask = st_ff.w_data[1:0];
        end
        nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);

        // every recorded error counts as uncorrectable and severe
        nxt_st.uncorr_err = |nxt_st.uncorr;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // functional state, cleared by the ordinary reset
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff                   <= '0;
            st_ff.rsp.bresp         <= RESP_OKAY;
            st_ff.rsp.rresp         <= RESP_OKAY;
            st_ff.dev.cto_value     <= CTO_VALUE_RST;
            st_ff.dev.cto_disable   <= CTO_DIS_RST;
            st_ff.dev.atomic_req_en <= ATOMIC_RST;
            st_ff.hasd              <= HASD_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // sticky link control fields, cleared by power-on reset only
    always_ff @(posedge clk_in or negedge por_resetn_in) begin
        if (!por_resetn_in) begin
            lnk_ff              <= '0;
            lnk_ff.target_speed <= TGT_SPEED_RST;
        end else begin
            lnk_ff <= nxt_lnk;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign axi_rsp_out      = st_ff.rsp;
    assign dev_ctl_out      = st_ff.dev;
    assign link_ctl_out     = lnk_ff;
    assign hw_speed_dis_out = st_ff.hasd;
    assign uncorr_err_out   = st_ff.uncorr_err;
    assign irq_out          = st_ff.irq;

endmodule

// *** cfg_regs_properties.sv ***
// checker for the capability-2 and error reporting register bank
// assumes it is bound to cfg_cap2_err_regs and sees only its ports
`timescale 1ns/10ps

module cfg_regs_properties
    import cfg_regs_pkg::*;
(
    // clock and resets
    input wire logic                    clk_in,
    input wire logic                    resetn_in,
    input wire logic                    por_resetn_in,
    // register bus
    input wire cfg_regs_pkg::axi_req_t  axi_req_in,
    input wire cfg_regs_pkg::axi_rsp_t  axi_rsp_out,
    // events, status and control
    input wire cfg_regs_pkg::err_evt_t  err_evt_in,
    input wire cfg_regs_pkg::eq_stat_t  eq_stat_in,
    input wire cfg_regs_pkg::dev_ctl_t  dev_ctl_out,
    input wire cfg_regs_pkg::link_ctl_t link_ctl_out,
    input wire logic                    hw_speed_dis_out,
    input wire logic                    uncorr_err_out,
    input wire logic                    irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // read address taken this edge
    logic ar_hs;
    assign ar_hs = axi_req_in.arvalid && axi_rsp_out.arready;

    // error flags: set by events, dropped only by a register write
    property p_evt_uncorr;
        |err_evt_in |=> uncorr_err_out;
    endproperty
    a_evt_uncorr: assert property (p_evt_uncorr)
        else $error("summary missed an error event");
    property p_clr_by_write;
        $fell(uncorr_err_out) |-> $rose(axi_rsp_out.bvalid);
    endproperty
    a_clr_by_write: assert property (p_clr_by_write)
        else $error("summary dropped without a write");
    property p_irq_cause;
        $rose(irq_out) |-> $past(|err_evt_in || eq_stat_in.req_set)
            || $rose(axi_rsp_out.bvalid);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt rose with no event or write");

    // values seen right after a functional reset, sticky fields held without a write
    property p_ctl_reset;
        $rose(resetn_in) |-> dev_ctl_out == {ATOMIC_RST, CTO_DIS_RST,
            CTO_VALUE_RST} && !hw_speed_dis_out && !uncorr_err_out;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("control fields wrong after reset");
    property p_sticky_hold;
        disable iff (!por_resetn_in)
        !$stable(link_ctl_out) |-> $rose(axi_rsp_out.bvalid);
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky link control changed without a write");

    // read data and write response timing
    property p_hdr_read;
        ar_hs && axi_req_in.araddr[11:2] == ERR_HDR_OFF[11:2] |=>
            axi_rsp_out.rvalid && axi_rsp_out.rdata[19:0] ==
            {ECAP_VER, ECAP_ID};
    endproperty
    a_hdr_read: assert property (p_hdr_read)
        else $error("capability header id or version wrong");
    property p_resv_zero;
        ar_hs && axi_req_in.araddr[11:2] == UNCORR_OFF[11:2] |=>
            (axi_rsp_out.rdata & ~UNCORR_IMPL) == 32'h0;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved status bits read nonzero");
    property p_b_latency;
        axi_req_in.awvalid && axi_rsp_out.awready && axi_req_in.wvalid
            && axi_rsp_out.wready |-> ##2 axi_rsp_out.bvalid;
    endproperty
    a_b_latency: assert property (p_b_latency)
        else $error("write response late");

    // main scenarios reached
    c_evt: cover property (|err_evt_in);
    c_clr: cover property ($fell(uncorr_err_out));
    c_irq: cover property ($rose(irq_out));
endmodule

bind cfg_cap2_err_regs cfg_regs_properties i_props (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .por_resetn_in(por_resetn_in), .axi_req_in(axi_req_in),
    .axi_rsp_out(axi_rsp_out), .err_evt_in(err_evt_in),
    .eq_stat_in(eq_stat_in), .dev_ctl_out(dev_ctl_out),
    .link_ctl_out(link_ctl_out), .hw_speed_dis_out(hw_speed_dis_out),
    .uncorr_err_out(uncorr_err_out), .irq_out(irq_out));

// *** cfg_host_model.sv ***
// host side model issuing configuration accesses as an AXI4-Lite master
// assumes tasks are entered just after a rising edge of clk_in
`timescale 1ns/10ps

module cfg_host_model
    import cfg_regs_pkg::*;
(
    // clock
    input  wire logic                   clk_in,
    // register bus
    output      cfg_regs_pkg::axi_req_t axi_req_out,
    input  wire cfg_regs_pkg::axi_rsp_t axi_rsp_in
);
    // response ready held high so no answer is ever refused
    initial axi_req_out = '{bready: 1'b1, rready: 1'b1, default: '0};

    // one write, data and strobes as given: a zero leaves a flag
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        axi_req_out.awaddr  <= a;
        axi_req_out.awvalid <= 1'b1;
        axi_req_out.wdata   <= d;
        axi_req_out.wstrb   <= s;
        axi_req_out.wvalid  <= 1'b1;
        do begin
            @(posedge clk_in);
            if (axi_req_out.awvalid && axi_rsp_in.awready) begin
                axi_req_out.awvalid <= 1'b0;
                axi_req_out.awaddr  <= ~a; // released lines do not hold
            end
            if (axi_req_out.wvalid && axi_rsp_in.wready) begin
                axi_req_out.wvalid <= 1'b0;
                axi_req_out.wdata  <= ~d;
            end
        end while (!axi_rsp_in.bvalid);
        r = axi_rsp_in.bresp;
    endtask

    // one read, data taken at the edge where rvalid is seen
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        axi_req_out.araddr  <= a;
        axi_req_out.arvalid <= 1'b1;
        do @(posedge clk_in); while (!axi_rsp_in.arready);
        axi_req_out.arvalid <= 1'b0;
        axi_req_out.araddr  <= ~a;
        do @(posedge clk_in); while (!axi_rsp_in.rvalid);
        d = axi_rsp_in.rdata;
        r = axi_rsp_in.rresp;
    endtask
endmodule

// *** tb.sv ***
// self-checking testbench for the capability-2 and error register bank
// assumes the host model as bus master and a 10 MHz clock
`timescale 1ns/10ps

module tb;
    import cfg_regs_pkg::*;
    logic        clk_in = 1'b0;
    logic        resetn_in;
    logic        por_resetn_in;
    axi_req_t    axi_req;
    axi_rsp_t    axi_rsp;
    err_evt_t    err_evt_in;
    eq_stat_t    eq_stat_in;
    dev_ctl_t    dev_ctl;
    link_ctl_t   link_ctl;
    logic        hsd;
    logic        uncorr;
    logic        irq;
    logic [31:0] rdat;
    logic [1:0]  resp;
    int          errors = 0;
    int          samples_checked = 0;

    // clock and units
    always #50 clk_in = ~clk_in;
    cfg_cap2_err_regs #(.CPL_TO_RANGES(4'h6), .LINK_SPEEDS(3'h3),
        .TPH_PRESENT(1'b1)) i_dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .por_resetn_in(por_resetn_in), .axi_req_in(axi_req),
        .axi_rsp_out(axi_rsp), .err_evt_in(err_evt_in),
        .eq_stat_in(eq_stat_in), .dev_ctl_out(dev_ctl),
        .link_ctl_out(link_ctl), .hw_speed_dis_out(hsd),
        .uncorr_err_out(uncorr), .irq_out(irq));
    cfg_host_model i_host (.clk_in(clk_in), .axi_req_out(axi_req),
        .axi_rsp_in(axi_rsp));

    // shared helpers
    task automatic check(input string n, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, exp, got);
        end
    endtask
    task automatic rchk(input string n, input logic [11:0] a,
                        input logic [31:0] e);
        i_host.rd(a, rdat, resp);
        check(n, rdat, e);
    endtask
    task automatic w(input logic [11:0] a, input logic [31:0] d);
        i_host.wr(a, d, 4'hF, resp);
    endtask
    task automatic pulse(input err_evt_t e);
        err_evt_in <= e;
        @(posedge clk_in);
        err_evt_in <= '0;
        @(posedge clk_in);
    endtask
    task automatic do_reset(input logic por);
        resetn_in <= 1'b0;
        por_resetn_in <= ~por;
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        por_resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask

    // scenarios
    task automatic t_reset_values();
        rchk("dev caps", DEV_CAP2_OFF, 32'h16);
        rchk("dev ctl", DEV_CTL2_OFF, 32'h1F);
        rchk("link caps", LNK_CAP2_OFF, 32'h6);
        rchk("link ctl", LNK_CTL2_OFF, 32'h1);
        rchk("hdr", ERR_HDR_OFF, {PTR_TPH, ECAP_VER, ECAP_ID});
        rchk("uncorr", UNCORR_OFF, 32'h0);
        i_host.rd(12'h0C0, rdat, resp);
        check("unmapped resp", resp, RESP_SLVERR);
    endtask
    task automatic t_writes();
        w(DEV_CAP2_OFF, 32'hFFFFFFFF);
        rchk("dev caps ro", DEV_CAP2_OFF, 32'h16);
        i_host.wr(DEV_CTL2_OFF, 32'hFFFFFFFF, 4'hE, resp);
        rchk("dev ctl strobe", DEV_CTL2_OFF, 32'h1F);
        w(DEV_CTL2_OFF, 32'hFFFFFFF0);
        rchk("dev ctl", DEV_CTL2_OFF, 32'h50);
        check("dev ctl out", dev_ctl, 6'h30);
        w(LNK_CTL2_OFF, 32'hFFFFFFF3);
        rchk("link ctl", LNK_CTL2_OFF, 32'hFFB3);
        check("hw speed dis", hsd, 1'b1);
        check("link ctl out", link_ctl, 14'h3FF3);
        w(ERR_HDR_OFF, 32'h0);
        rchk("hdr ro", ERR_HDR_OFF, {PTR_TPH, ECAP_VER, ECAP_ID});
    endtask
    task automatic t_errors();
        int pos;
        for (int i = 0; i < 10; i++) begin
            pulse(err_evt_t'(10'h1 << i));
            pos = (i == 0) ? 4 : 11 + i;
            check("uncorr out", uncorr, 1'b1);
            w(UNCORR_OFF, ~(32'h1 << pos));
            rchk("flag kept", UNCORR_OFF, 32'h1 << pos);
            w(UNCORR_OFF, 32'h1 << pos);
            rchk("flag clear", UNCORR_OFF, 32'h0);
            check("uncorr out", uncorr, 1'b0);
        end
    endtask
    task automatic t_race();
        pulse(err_evt_t'(10'h200));
        fork
            w(UNCORR_OFF, 32'h00100000);
            begin
                @(posedge clk_in);
                err_evt_in <= err_evt_t'(10'h200);
                @(posedge clk_in);
                err_evt_in <= '0;
            end
        join
        rchk("set beats clear", UNCORR_OFF, 32'h00100000);
        w(UNCORR_OFF, 32'h00100000);
        rchk("flag clear", UNCORR_OFF, 32'h0);
    endtask
    task automatic t_eq();
        eq_stat_in <= 5'h0F;
        @(posedge clk_in);
        rchk("eq status", LNK_CTL2_OFF, 32'h001EFFB3);
        eq_stat_in <= 5'h1F;
        @(posedge clk_in);
        eq_stat_in <= 5'h0F;
        @(posedge clk_in);
        rchk("eq request", LNK_CTL2_OFF, 32'h003EFFB3);
        w(LNK_CTL2_OFF, 32'h0000FFF3);
        rchk("eq kept", LNK_CTL2_OFF, 32'h003EFFB3);
        w(LNK_CTL2_OFF, 32'h0020FFF3);
        rchk("eq cleared", LNK_CTL2_OFF, 32'h001EFFB3);
        eq_stat_in <= '0;
    endtask
    task automatic t_irq();
        w(INT_STAT_OFF, 32'h3);
        rchk("int stat", INT_STAT_OFF, 32'h0);
        pulse(err_evt_t'(10'h1));
        rchk("int stat", INT_STAT_OFF, 32'h1);
        check("irq masked", irq, 1'b0);
        w(INT_MASK_OFF, 32'h1);
        check("irq", irq, 1'b1);
        w(INT_STAT_OFF, 32'h1);
        check("irq cleared", irq, 1'b0);
        w(UNCORR_OFF, 32'h10);
    endtask
    task automatic t_sticky();
        do_reset(1'b0);
        check("link kept", link_ctl, 14'h3FF3);
        check("hw speed dis", hsd, 1'b0);
        rchk("dev ctl back", DEV_CTL2_OFF, 32'h1F);
        do_reset(1'b1);
        rchk("link ctl por", LNK_CTL2_OFF, 32'h1);
    endtask

    // verdict
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        err_evt_in <= '0;
        eq_stat_in <= '0;
        do_reset(1'b1);
        t_reset_values();
        t_writes();
        t_errors();
        t_race();
        t_eq();
        t_irq();
        t_sticky();
        end_of_test();
    end
endmodule
